// [verilog/rac_pkg.sv]
// package: register map, field positions and reset values of the alarm/control block
package rac_pkg;
    // register offsets
    localparam logic [7:0] ADDR_CONTROL = 8'h0E;
    localparam logic [7:0] ADDR_FLAGS = 8'h0F;
    localparam logic [7:0] ADDR_CHARGER = 8'h10;
    // control field positions
    localparam int CTL_HALT = 7;
    localparam int CTL_BACKUP_EN = 5;
    localparam int CTL_RATE_HI = 4;
    localparam int CTL_RATE_LO = 3;
    localparam int CTL_OUT_SEL = 2;
    localparam int CTL_A2_IE = 1;
    localparam int CTL_A1_IE = 0;
    // flags field positions
    localparam int FLG_OSC_STOP = 7;
    localparam int FLG_A2 = 1;
    localparam int FLG_A1 = 0;
    // writable masks and reset values
    localparam logic [7:0] CONTROL_MASK = 8'hBF;
    localparam logic [7:0] CONTROL_RESET = 8'h18;
    localparam logic [7:0] CHARGER_RESET = 8'h00;
    localparam logic [3:0] CHARGER_KEY = 4'hA;
    // alarm register fields
    localparam int MASK_BIT = 7;
    localparam int DAY_SEL_BIT = 6;
    // oscillator and timing
    localparam int OSC_HZ = 32768;
    localparam int CLK_HZ = 40000000;
    // 32.768 kHz tick period in 40 MHz cycles, rounded down
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    // square-wave divider taps on a 15-bit chain: 1 Hz, 4096 Hz, 8192 Hz
    localparam int TAP_1HZ = 14;
    localparam int TAP_4K = 2;
    localparam int TAP_8K = 1;
    // rate select codes
    typedef enum logic [1:0] {
        RAC_RATE_1HZ = 2'h0,
        RAC_RATE_4K = 2'h1,
        RAC_RATE_8K = 2'h2,
        RAC_RATE_32K = 2'h3
    } rac_rate_type;
    // current time, BCD, as fed from the timekeeping counters
    typedef struct packed {
        logic [6:0] sec;
        logic [6:0] min;
        logic [6:0] hour;
        logic [2:0] wday;
        logic [5:0] date;
    } rac_time_type;
    // one alarm setting as four register bytes
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] day;
    } rac_alarm_type;
    // charger path decode
    typedef struct packed {
        logic enable;
        logic diode;
        logic [1:0] resistor;
    } rac_charge_type;
endpackage

// [verilog/rac_alarm_ctrl.sv]
// alarm match, output select, status flags and charger path decode
//
// Behaviour
// R01 - all alarm-one masks set fires each second; seconds-only unmasked matches seconds
// R02 - alarm one matches minutes+seconds, then hours+minutes+seconds as masks clear
// R03 - all alarm-one masks clear adds date, or weekday when select bit is one
// R04 - all alarm-two masks set fires at second 00 of each minute
// R05 - alarm two matches minutes, then hours and minutes as masks clear
// R06 - all alarm-two masks clear adds date, or weekday when select is one
// R07 - control bit 7 stops oscillator when one, runs it when zero; resets zero
// R08 - backup enable keeps output active on backup; else output floats on power fail
// R09 - rate bits choose 1 Hz, 4.096, 8.192 or 32.768 kHz square wave
// R10 - both rate bits reset to one, highest frequency
// R11 - output select bit 2 routes wave at zero, alarm interrupt at one; resets zero
// R12 - interrupt low when an enabled alarm flag is set; disabled flags ignored
// R13 - alarm enables and backup enable reset to zero
// R14 - oscillator-stop flag sets on power-up, supply loss, or halt bit
// R15 - oscillator-stop flag stays set until written zero; writing one does nothing
// R16 - alarm flag sets on match; write zero clears, write one keeps it
// R17 - charger enabled only with upper key nibble exactly 1010
// R18 - diode select 01 no diode, 10 one diode; 00 and 11 disable
// R19 - resistor select 01 250 ohm, 10 2k, 11 4k; 00 disables
// R20 - charger register resets to all zero
// R21 - software must not pick lowest resistor above the supply limit
// R22 - alarms compared against time once per second, flags set on match
// R23 - bit 6 of alarm day register picks weekday (1) or date (0)
// R24 - interrupt stays asserted until software clears the causing flag
// R25 - unused control and status bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module rac_alarm_ctrl #(
    parameter int OSC_DIV = rac_pkg::OSC_DIV
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    // register port from the serial slave
    input wire logic I_REG_WR,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    // time counters and alarm settings
    input wire logic I_SEC_TICK,
    input wire rac_pkg::rac_time_type I_TIME,
    input wire rac_pkg::rac_alarm_type I_ALARM_ONE,
    input wire rac_pkg::rac_alarm_type I_ALARM_TWO,
    // power and oscillator status
    input wire logic I_ON_BACKUP,
    input wire logic I_OSC_FAIL,
    // shared output pin, open drain in interrupt mode
    output logic O_WAVE_OR_IRQ_OUT,
    output logic O_WAVE_OR_IRQ_OE,
    // oscillator and charger controls
    output logic O_OSC_RUN,
    output rac_pkg::rac_charge_type O_CHARGE
);
    initial begin
        if (OSC_DIV < 2) begin
            $error("OSC_DIV must be at least 2");
        end
        // the tick counter is only 16 bits wide
        if (OSC_DIV > 65536) begin
            $error("OSC_DIV must not exceed 65536");
        end
    end

    // register images, status flags and timing state
    logic [7:0] rtc_control;
    logic [7:0] charger_config;
    logic alarm_one_flag;
    logic alarm_two_flag;
    logic osc_stopped_flag;
    logic osc_halt_d;
    logic [15:0] osc_cnt;
    logic osc_tick;
    logic osc_half;
    logic [14:0] wave_chain;
    logic alarm_one_hit;
    logic alarm_two_hit;
    logic wr_flags;
    logic oscillator_halt;
    logic backup_output_enable;
    logic output_select;
    logic alarm_one_irq_enable;
    logic alarm_two_irq_enable;
    logic [1:0] rate_sel;
    logic next_wave;
    logic next_irq_n;
    logic [3:0] charger_unlock_key;
    logic [1:0] diode_select;
    logic [1:0] charge_resistor_select;
    logic a1_sec_eq;
    logic a1_min_eq;
    logic a1_hour_eq;
    logic a1_day_eq;
    logic a2_min_eq;
    logic a2_hour_eq;
    logic a2_day_eq;

    // control field views
    // decoding from the stored byte keeps one source per field
    assign oscillator_halt = rtc_control[rac_pkg::CTL_HALT];
    assign backup_output_enable = rtc_control[rac_pkg::CTL_BACKUP_EN];
    assign rate_sel = {rtc_control[rac_pkg::CTL_RATE_HI], rtc_control[rac_pkg::CTL_RATE_LO]};
    assign output_select = rtc_control[rac_pkg::CTL_OUT_SEL];
    assign alarm_two_irq_enable = rtc_control[rac_pkg::CTL_A2_IE];
    assign alarm_one_irq_enable = rtc_control[rac_pkg::CTL_A1_IE];
    assign wr_flags = I_REG_WR && (I_REG_ADDR == rac_pkg::ADDR_FLAGS);

    // control register write
    // written fields act from the next edge; there is no shadow copy
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            // R07 halt resets zero
            // R10 rate bits reset high
            // R13 enables reset zero
            rtc_control <= rac_pkg::CONTROL_RESET;
        end else if (I_REG_WR && (I_REG_ADDR == rac_pkg::ADDR_CONTROL)) begin
            // R25 bit 6 held at zero
            rtc_control <= I_REG_WDATA & rac_pkg::CONTROL_MASK;
        end
    end

    // charger register write
    // stored as written, so a read shows exactly what software wrote
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            // R20 charger clear at reset
            charger_config <= rac_pkg::CHARGER_RESET;
        end else if (I_REG_WR && (I_REG_ADDR == rac_pkg::ADDR_CHARGER)) begin
            charger_config <= I_REG_WDATA;
        end
    end

    // alarm one field comparisons
    // 12/24 and am/pm bits compare as stored, so both sides must agree
    always_comb begin
        a1_sec_eq = (I_ALARM_ONE.sec[6:0] == I_TIME.sec);
        a1_min_eq = (I_ALARM_ONE.min[6:0] == I_TIME.min);
        a1_hour_eq = (I_ALARM_ONE.hour[6:0] == I_TIME.hour);
        // R23 weekday or date compare
        if (I_ALARM_ONE.day[rac_pkg::DAY_SEL_BIT]) begin
            a1_day_eq = (I_ALARM_ONE.day[5:0] == {3'h0, I_TIME.wday});
        end else begin
            a1_day_eq = (I_ALARM_ONE.day[5:0] == I_TIME.date);
        end
    end

    // alarm two field comparisons
    // the alarm-two seconds byte has no role; second zero gates it below
    always_comb begin
        a2_min_eq = (I_ALARM_TWO.min[6:0] == I_TIME.min);
        a2_hour_eq = (I_ALARM_TWO.hour[6:0] == I_TIME.hour);
        // R23 weekday or date compare
        if (I_ALARM_TWO.day[rac_pkg::DAY_SEL_BIT]) begin
            a2_day_eq = (I_ALARM_TWO.day[5:0] == {3'h0, I_TIME.wday});
        end else begin
            a2_day_eq = (I_ALARM_TWO.day[5:0] == I_TIME.date);
        end
    end

    // masked match: a set mask bit makes that field always agree
    // unlisted mask mixes simply follow the same and-of-fields rule
    always_comb begin
        // R01 seconds field or every second
        // R02 minutes and hours join in
        // R03 day or date joins in
        alarm_one_hit = (I_ALARM_ONE.sec[rac_pkg::MASK_BIT] || a1_sec_eq)
            && (I_ALARM_ONE.min[rac_pkg::MASK_BIT] || a1_min_eq)
            && (I_ALARM_ONE.hour[rac_pkg::MASK_BIT] || a1_hour_eq)
            && (I_ALARM_ONE.day[rac_pkg::MASK_BIT] || a1_day_eq);
        // R04 once per minute at second zero
        // R05 minutes then hours
        // R06 day or date joins in
        alarm_two_hit = (I_TIME.sec == 7'h00)
            && (I_ALARM_TWO.min[rac_pkg::MASK_BIT] || a2_min_eq)
            && (I_ALARM_TWO.hour[rac_pkg::MASK_BIT] || a2_hour_eq)
            && (I_ALARM_TWO.day[rac_pkg::MASK_BIT] || a2_day_eq);
    end

    // alarm flags: match on the second tick wins over a software clear
    // a clear lost to a match leaves the flag set, so software re-reads
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            alarm_one_flag <= 1'b0;
            alarm_two_flag <= 1'b0;
        end else begin
            // R22 compare once per second
            // R16 set on match, clear by zero only
            if (I_SEC_TICK && alarm_one_hit) begin
                alarm_one_flag <= 1'b1;
            end else if (wr_flags && !I_REG_WDATA[rac_pkg::FLG_A1]) begin
                alarm_one_flag <= 1'b0;
            end
            if (I_SEC_TICK && alarm_two_hit) begin
                alarm_two_flag <= 1'b1;
            end else if (wr_flags && !I_REG_WDATA[rac_pkg::FLG_A2]) begin
                alarm_two_flag <= 1'b0;
            end
        end
    end

    // oscillator stop flag, set on a rising halt bit or every cycle failure is high
    // a held halt bit sets it once; software may clear it while halted
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            // R14 power-up counts as a stop
            osc_stopped_flag <= 1'b1;
            osc_halt_d <= 1'b0;
        end else begin
            osc_halt_d <= oscillator_halt;
            // R14 rising halt or failure sets it
            // R15 only a zero write clears
            if ((oscillator_halt && !osc_halt_d) || I_OSC_FAIL) begin
                osc_stopped_flag <= 1'b1;
            end else if (wr_flags && !I_REG_WDATA[rac_pkg::FLG_OSC_STOP]) begin
                osc_stopped_flag <= 1'b0;
            end
        end
    end

    // 32.768 kHz tick enable from the system clock; frozen while halted
    // the divide is rounded down, so the tick runs slightly fast
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            osc_cnt <= 16'h0000;
            osc_tick <= 1'b0;
        end else if (oscillator_halt) begin
            osc_cnt <= 16'h0000;
            osc_tick <= 1'b0;
        end else if (osc_cnt == 16'(OSC_DIV - 1)) begin
            osc_cnt <= 16'h0000;
            osc_tick <= 1'b1;
        end else begin
            osc_cnt <= osc_cnt + 16'h0001;
            osc_tick <= 1'b0;
        end
    end

    // R09 top rate from the tick counter
    // chain bit 0 only reaches half the tick rate, so use the counter's halves
    assign osc_half = (osc_cnt >= 16'(OSC_DIV / 2));

    // countdown chain: bit n toggles at 32768 / 2^(n+1) Hz
    // one chain feeds every tap, so a rate change keeps the phase
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            wave_chain <= 15'h0000;
        end else if (osc_tick) begin
            wave_chain <= wave_chain + 15'h0001;
        end
    end

    // halted: chain freezes and counter clears, so the pin holds its level except at 32 kHz, where it sits low
    // R09 square-wave frequency select
    always_comb begin
        case (rac_pkg::rac_rate_type'(rate_sel))
            rac_pkg::RAC_RATE_1HZ: next_wave = wave_chain[rac_pkg::TAP_1HZ];
            rac_pkg::RAC_RATE_4K: next_wave = wave_chain[rac_pkg::TAP_4K];
            rac_pkg::RAC_RATE_8K: next_wave = wave_chain[rac_pkg::TAP_8K];
            rac_pkg::RAC_RATE_32K: next_wave = osc_half;
            default: next_wave = 1'b0;
        endcase
    end

    // R12 only enabled flags pull the interrupt low
    // R24 held until flag cleared
    assign next_irq_n = !((alarm_one_flag && alarm_one_irq_enable)
        || (alarm_two_flag && alarm_two_irq_enable));

    // shared pin: wave is push-pull, interrupt is open drain
    // oe low lets the board's pull-up hold the interrupt line high
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_WAVE_OR_IRQ_OUT <= 1'b0;
            O_WAVE_OR_IRQ_OE <= 1'b0;
        end else if (I_ON_BACKUP && !backup_output_enable) begin
            // R08 float on backup unless enabled
            O_WAVE_OR_IRQ_OUT <= 1'b0;
            O_WAVE_OR_IRQ_OE <= 1'b0;
        end else if (output_select) begin
            // R11 interrupt mode
            O_WAVE_OR_IRQ_OUT <= 1'b0;
            O_WAVE_OR_IRQ_OE <= !next_irq_n;
        end else begin
            // R11 square-wave mode
            O_WAVE_OR_IRQ_OUT <= next_wave;
            O_WAVE_OR_IRQ_OE <= 1'b1;
        end
    end

    // charger key and path fields
    assign charger_unlock_key = charger_config[7:4];
    assign diode_select = charger_config[3:2];
    assign charge_resistor_select = charger_config[1:0];

    // charger path decode, registered
    // path bits pass on even when disabled; enable alone gates the switch
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_CHARGE <= '0;
        end else begin
            // R17 exact key unlocks
            // R18 diode codes 00 and 11 block
            // R19 resistor code 00 blocks
            // R21 lowest resistor is software's responsibility
            O_CHARGE.enable <= (charger_unlock_key == rac_pkg::CHARGER_KEY)
                && (diode_select[1] ^ diode_select[0])
                && (charge_resistor_select != 2'h0);
            O_CHARGE.diode <= diode_select[1];
            O_CHARGE.resistor <= charge_resistor_select;
        end
    end

    // registered like every other pin, one cycle after the write
    // R07 halt bit stops oscillator
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_OSC_RUN <= 1'b0;
        end else begin
            O_OSC_RUN <= !oscillator_halt;
        end
    end

    // read data, registered so it is stable one cycle after the address
    // reads have no side effects; flags clear only on an explicit write
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_REG_RDATA <= 8'h00;
        end else begin
            case (I_REG_ADDR)
                rac_pkg::ADDR_CONTROL: O_REG_RDATA <= rtc_control;
                // R25 unused status bits read zero
                rac_pkg::ADDR_FLAGS: O_REG_RDATA <= {osc_stopped_flag, 5'h00,
                    alarm_two_flag, alarm_one_flag};
                rac_pkg::ADDR_CHARGER: O_REG_RDATA <= charger_config;
                default: O_REG_RDATA <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// [tb/rac_alarm_ctrl_chk.sv]
// port-level concurrent checks of the alarm/control block
`timescale 1ns/1ps
`default_nettype none
module rac_alarm_ctrl_chk #(
    parameter int OSC_DIV = rac_pkg::OSC_DIV
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    // register port
    input wire logic I_REG_WR,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic [7:0] O_REG_RDATA,
    // supply status and outputs
    input wire logic I_ON_BACKUP,
    input wire logic O_WAVE_OR_IRQ_OUT,
    input wire logic O_WAVE_OR_IRQ_OE,
    input wire logic O_OSC_RUN,
    input wire rac_pkg::rac_charge_type O_CHARGE
);
    logic [7:0] ctl;
    logic ctl_wr;
    logic chg_wr;
    assign ctl_wr = I_REG_WR && I_REG_ADDR == rac_pkg::ADDR_CONTROL;
    assign chg_wr = I_REG_WR && I_REG_ADDR == rac_pkg::ADDR_CHARGER;
    // control mirror, so mode checks need no view of the body
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ctl <= rac_pkg::CONTROL_RESET;
        end else if (ctl_wr) begin
            ctl <= I_REG_WDATA & rac_pkg::CONTROL_MASK;
        end
    end
    default clocking dcb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    property p_halt;
        ctl_wr ##1 !ctl_wr |=> O_OSC_RUN == !$past(I_REG_WDATA[7], 2);
    endproperty
    a_halt: assert property (p_halt) else $error("run level off");
    property p_ctl_gap;
        I_REG_ADDR == rac_pkg::ADDR_CONTROL |=> !O_REG_RDATA[6];
    endproperty
    a_ctl_gap: assert property (p_ctl_gap) else $error("control bit 6 set");
    property p_flg_gap;
        I_REG_ADDR == rac_pkg::ADDR_FLAGS |=> O_REG_RDATA[6:2] == 5'h00;
    endproperty
    a_flg_gap: assert property (p_flg_gap) else $error("flags gap set");
    property p_unmap;
        !(I_REG_ADDR inside {[8'h0E:8'h10]}) |=> O_REG_RDATA == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_key;
        chg_wr && I_REG_WDATA[7:4] != rac_pkg::CHARGER_KEY ##1 !chg_wr |=> !O_CHARGE.enable;
    endproperty
    a_key: assert property (p_key) else $error("charger on without key");
    property p_chg_on;
        chg_wr && I_REG_WDATA[7:4] == 4'hA && ^I_REG_WDATA[3:2] && |I_REG_WDATA[1:0]
            ##1 !chg_wr |=> O_CHARGE == {1'b1, $past(I_REG_WDATA[3], 2), $past(I_REG_WDATA[1:0], 2)};
    endproperty
    a_chg_on: assert property (p_chg_on) else $error("charger path");
    property p_wave_oe;
        !ctl[2] && !I_ON_BACKUP |=> O_WAVE_OR_IRQ_OE;
    endproperty
    a_wave_oe: assert property (p_wave_oe) else $error("wave not driven");
    property p_backup;
        I_ON_BACKUP && !ctl[5] |=> !O_WAVE_OR_IRQ_OE;
    endproperty
    a_backup: assert property (p_backup) else $error("pin driven on backup");
    property p_irq_low;
        ctl[2] |=> !O_WAVE_OR_IRQ_OE || !O_WAVE_OR_IRQ_OUT;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq drives high");
    property p_irq_hold;
        ctl[2] && O_WAVE_OR_IRQ_OE && !I_REG_WR && !$past(I_REG_WR) && !I_ON_BACKUP
            |=> O_WAVE_OR_IRQ_OE;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq released");
    c_irq: cover property (ctl[2] && O_WAVE_OR_IRQ_OE);
    c_chg: cover property (O_CHARGE.enable);
    c_bkp: cover property (I_ON_BACKUP && !O_WAVE_OR_IRQ_OE);
endmodule
bind rac_alarm_ctrl rac_alarm_ctrl_chk #(.OSC_DIV(OSC_DIV)) u_rac_alarm_ctrl_chk (
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_REG_WR(I_REG_WR), .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA), .I_ON_BACKUP(I_ON_BACKUP),
    .O_WAVE_OR_IRQ_OUT(O_WAVE_OR_IRQ_OUT), .O_WAVE_OR_IRQ_OE(O_WAVE_OR_IRQ_OE),
    .O_OSC_RUN(O_OSC_RUN), .O_CHARGE(O_CHARGE));
`default_nettype wire

// [tb/rac_host.sv]
// register-port host standing in for the serial bus master
`timescale 1ns/1ps
`default_nettype none
module rac_host (
    // clock
    input wire logic i_clk,
    // register port toward the block
    output var logic o_wr,
    output var logic [7:0] o_addr,
    output var logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata
);
    logic [7:0] data;
    event got;
    initial begin
        o_wr = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    // one byte write; data scrambled after, nothing may lean on stale bytes
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= v;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~v;
    endtask
    // address held two edges: one to register, one to sample
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        o_addr <= a;
        repeat (2) @(posedge i_clk);
        data = i_rdata;
        -> got;
    endtask
endmodule
`default_nettype wire

// [tb/rac_alarm_ctrl_tb_top.sv]
// self-checking testbench of the alarm/control block
`timescale 1ns/1ps
`default_nettype none
module rac_alarm_ctrl_tb_top;
    localparam logic [7:0] ad_ctl = rac_pkg::ADDR_CONTROL;
    localparam logic [7:0] ad_flg = rac_pkg::ADDR_FLAGS;
    localparam logic [7:0] ad_chg = rac_pkg::ADDR_CHARGER;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0;
    logic bkp = 1'b0;
    logic ofail = 1'b0;
    rac_pkg::rac_time_type tm = {7'h30, 7'h15, 7'h08, 3'h3, 6'h21};
    rac_pkg::rac_alarm_type a1 = '0;
    rac_pkg::rac_alarm_type a2 = '0;
    logic wr, oe, out, run;
    logic [7:0] addr, wdata, rdata;
    rac_pkg::rac_charge_type chg;
    logic [7:0] exp_q[$];
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    // 40 MHz
    always #12.5 clk = ~clk;
    rac_alarm_ctrl #(.OSC_DIV(2)) u_rac_alarm_ctrl (.I_CLK(clk), .I_SYS_RST(rst),
        .I_REG_WR(wr), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
        .I_SEC_TICK(tick), .I_TIME(tm), .I_ALARM_ONE(a1), .I_ALARM_TWO(a2),
        .I_ON_BACKUP(bkp), .I_OSC_FAIL(ofail), .O_WAVE_OR_IRQ_OUT(out),
        .O_WAVE_OR_IRQ_OE(oe), .O_OSC_RUN(run), .O_CHARGE(chg));
    rac_host u_rac_host (.i_clk(clk), .o_wr(wr), .o_addr(addr), .o_wdata(wdata),
        .i_rdata(rdata));
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_rac_host.rd(a);
    endtask
    // oldest note against each read result
    always @(u_rac_host.got) chk("rdata", exp_q.pop_front(), u_rac_host.data);
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    // clear flags, present time and alarms, one second tick, read flags
    task automatic alarm(input logic [6:0] s, input logic [31:0] x1, input logic [23:0] x2,
        input logic [7:0] e);
        u_rac_host.wr(ad_flg, 8'h00);
        @(posedge clk);
        tm.sec <= s;
        a1 <= x1;
        a2 <= {8'h00, x2};
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        rd(ad_flg, e);
    endtask
    task automatic pin(input logic e);
        repeat (3) @(posedge clk);
        chk("oe", {7'h00, e}, {7'h00, oe});
    endtask
    // rising edges of the pin over 64 cycles for one rate code
    task automatic wave(input logic [7:0] c, input int e);
        int n;
        logic prev;
        n = 0;
        u_rac_host.wr(ad_ctl, c);
        repeat (4) @(posedge clk);
        prev = out;
        repeat (64) begin
            @(posedge clk);
            if (out && !prev) n++;
            prev = out;
        end
        chk("wave", 8'(e), 8'(n));
    endtask
    // disabled charger only shows enable; path bits are then free
    task automatic charge(input logic [7:0] v, input logic [3:0] e);
        u_rac_host.wr(ad_chg, v);
        repeat (2) @(posedge clk);
        chk("charge", {4'h0, e}, e[3] ? {4'h0, chg} : {7'h00, chg.enable} << 3);
    endtask
    initial begin
        int seed;
        logic [3:0] key;
        seed = $urandom(32967);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(ad_ctl, 8'h18);
        rd(ad_flg, 8'h80);
        rd(ad_chg, 8'h00);
        rd(8'h11, 8'h00);
        u_rac_host.wr(ad_flg, 8'h00);
        rd(ad_flg, 8'h00);
        u_rac_host.wr(ad_ctl, 8'hFF);
        rd(ad_ctl, 8'hBF);
        chk("run", 8'h00, {7'h00, run});
        rd(ad_flg, 8'h80);
        u_rac_host.wr(ad_flg, 8'hFF);
        rd(ad_flg, 8'h80);
        u_rac_host.wr(ad_ctl, 8'h00);
        repeat (2) @(posedge clk);
        chk("run", 8'h01, {7'h00, run});
        u_rac_host.wr(ad_flg, 8'h00);
        ofail <= 1'b1;
        @(posedge clk);
        ofail <= 1'b0;
        rd(ad_flg, 8'h80);
        alarm(7'h30, 32'h80808080, 24'h808080, 8'h01);
        alarm(7'h30, 32'h31808080, 24'h808080, 8'h00);
        alarm(7'h30, 32'h30808080, 24'h808080, 8'h01);
        alarm(7'h30, 32'h30168080, 24'h808080, 8'h00);
        alarm(7'h30, 32'h30150880, 24'h808080, 8'h01);
        alarm(7'h30, 32'h30150821, 24'h808080, 8'h01);
        alarm(7'h30, 32'h30150843, 24'h808080, 8'h01);
        alarm(7'h30, 32'h30150844, 24'h808080, 8'h00);
        alarm(7'h00, 32'h80808080, 24'h808080, 8'h03);
        alarm(7'h00, 32'h01808080, 24'h158080, 8'h02);
        alarm(7'h00, 32'h01808080, 24'h150980, 8'h00);
        alarm(7'h00, 32'h01808080, 24'h150821, 8'h02);
        alarm(7'h00, 32'h01808080, 24'h150843, 8'h02);
        alarm(7'h00, 32'h01808080, 24'h150822, 8'h00);
        u_rac_host.wr(ad_ctl, 8'h05);
        alarm(7'h30, 32'h80808080, 24'h808080, 8'h01);
        pin(1'b1);
        repeat (20) @(posedge clk);
        pin(1'b1);
        u_rac_host.wr(ad_flg, 8'h00);
        pin(1'b0);
        alarm(7'h00, 32'h01808080, 24'h808080, 8'h02);
        pin(1'b0);
        u_rac_host.wr(ad_ctl, 8'h18);
        bkp <= 1'b1;
        pin(1'b0);
        u_rac_host.wr(ad_ctl, 8'h38);
        pin(1'b1);
        bkp <= 1'b0;
        // two cycles per crystal tick here: 64 cycles hold 4, 8 and 32 periods
        wave(8'h08, 4);
        wave(8'h10, 8);
        wave(8'h18, 32);
        key = 4'($urandom_range(9));
        charge({key, 4'h5}, 4'h0);
        charge(8'hA5, 4'b1001);
        charge(8'hAA, 4'b1110);
        charge(8'hAB, 4'b1111);
        charge(8'hAF, 4'h0);
        charge(8'hA3, 4'h0);
        charge(8'hA4, 4'h0);
        rd(ad_chg, 8'hA4);
        @(posedge clk);
        summarize();
    end
endmodule
`default_nettype wire
